// file: logic/selftest_pkg.sv
package selftest_pkg;

	// ------------------------------------------------
	// register offsets
	// ------------------------------------------------
	localparam logic [5:0] ADDR_DAC_CFG = 6'h03;
	localparam logic [5:0] ADDR_SOFT_RESET = 6'h07;
	localparam logic [5:0] ADDR_TRIGGER = 6'h0a;
	localparam logic [5:0] ADDR_SPECIAL = 6'h0b;
	localparam logic [5:0] ADDR_ALARM_ACTION = 6'h10;
	localparam logic [5:0] ADDR_SCRATCH = 6'h18;
	localparam logic [5:0] ADDR_GENERAL_STATUS = 6'h20;
	localparam logic [5:0] ADDR_CRC_RESULT = 6'h3e;
	localparam logic [5:0] ADDR_EXP_CRC = 6'h3f;

	// ------------------------------------------------
	// field positions and codes
	// ------------------------------------------------
	localparam int DAC_PD_BIT = 0;
	localparam int TRIG_TRIM_BIT = 0;
	localparam int TRIG_SELF_BIT = 4;
	localparam int SPECIAL_TRIM_BIT = 0;
	localparam int STATUS_SELF_BIT = 0;
	localparam int STATUS_CRCERR_BIT = 1;
	localparam logic [7:0] SOFT_RESET_CODE = 8'had;
	localparam logic [15:0] SCRATCH_RESET = 16'h0000;

	// ------------------------------------------------
	// crc engine
	// ------------------------------------------------
	localparam logic [15:0] CRC_POLY = 16'h755b;
	localparam logic [15:0] CRC_INIT = 16'h0000;

	// ------------------------------------------------
	// covered registers, in check order
	// ------------------------------------------------
	localparam int NUM_COVERED = 22;
	localparam logic [4:0] LAST_COVERED = 5'd21;
	localparam int IDX_DAC_DATA = 0;
	localparam int IDX_DAC_CFG = 2;
	localparam int IDX_SPECIAL = 8;
	localparam int IDX_ALARM_ACTION = 12;
	localparam logic [5:0] COVER_ADDR [NUM_COVERED] = '{
		6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h08, 6'h09, 6'h0b, 6'h0d, 6'h0e,
		6'h0f, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h1b, 6'h1d, 6'h1e, 6'h1f, 6'h3f};
	localparam logic [15:0] COVER_RESET [NUM_COVERED] = '{
		16'h0000, 16'h0036, 16'h0b00, 16'h8000, 16'h0000, 16'h0000, 16'h8810,
		16'h0080, 16'h0000, 16'h0100, 16'h0040, 16'h00f0, 16'h8020, 16'h0018,
		16'hff00, 16'hff00, 16'hff00, 16'h00ff, 16'hefdf, 16'hffff, 16'hffff,
		16'h0000};
	localparam logic [NUM_COVERED-1:0] COVER_RSVD = 22'h100e00;

	// ------------------------------------------------
	// timing
	// ------------------------------------------------
	localparam int CLK_FREQ_KHZ = 20000;
	localparam int T_POR_MAX_US = 100;
	localparam int POR_MAX_CYCLES = T_POR_MAX_US * CLK_FREQ_KHZ / 1000;

	typedef enum logic [1:0] {
		ST_WAIT = 2'b00,
		ST_IDLE = 2'b01,
		ST_SELF = 2'b10,
		ST_TRIM = 2'b11
	} state_t;

	function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [15:0] w);
		logic [15:0] r;
		r = c;
		for (int b = 15; b >= 0; b--) begin
			r = {r[14:0], 1'b0} ^ ((r[15] ^ w[b]) ? CRC_POLY : 16'h0000);
		end
		return r;
	endfunction

endpackage

// file: logic/register_selftest_reset_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module register_selftest_reset_ctrl
	import selftest_pkg::*;
#(
	parameter int TRIM_WORDS = 16
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic supplyValid,
	input wire logic resetPinN,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [5:0] regAddr,
	input wire logic [15:0] regWdata,
	output logic [15:0] regRdata,
	output logic regBusy,
	input wire logic [15:0] alarmEvents,
	output logic dacPowerDown,
	output logic dacAmpEnable,
	output logic [15:0] dacData,
	output logic trimLoading,
	output logic [4:0] trimAddr,
	input wire logic [15:0] trimData,
	output logic alarmPinN
);

	// ------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------
	logic [1:0] supplySync_q;
	logic [1:0] pinSync_q;
	logic supplyOk;
	logic hwRst;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			supplySync_q <= 2'b00;
			pinSync_q <= 2'b11;
		end else begin
			supplySync_q <= {supplySync_q[0], supplyValid};
			pinSync_q <= {pinSync_q[0], resetPinN};
		end
	end

	assign supplyOk = supplySync_q[1];
	assign hwRst = ~pinSync_q[1];

	// ------------------------------------------------
	// state
	// ------------------------------------------------
	state_t state_q, state_d;
	logic [4:0] idx_q, idx_d;
	logic [15:0] crc_q, crc_d;
	logic flag_q, flag_d;
	logic crcErr_q, crcErr_d;
	logic porDone_q, porDone_d;
	logic softRst_q, softRst_d;
	logic alarmPinN_q, alarmPinN_d;
	logic dacPd_q, dacPd_d;
	logic [15:0] regs_q [NUM_COVERED];
	logic [15:0] regs_d [NUM_COVERED];
	logic [15:0] scratch_q, scratch_d;
	logic [15:0] rdata_q, rdata_d;
	logic [15:0] rdValue;
	logic [15:0] coverWord;
	logic wrOk, rdOk, regClr, statusRead;

	assign regBusy = (state_q == ST_SELF);
	assign wrOk = regWrite && !regBusy;
	assign rdOk = regRead && !regBusy;
	assign regClr = hwRst || softRst_q;
	assign statusRead = rdOk && (regAddr == ADDR_GENERAL_STATUS);
	assign coverWord = COVER_RSVD[idx_q] ? COVER_RESET[idx_q] : regs_q[idx_q];

	// ------------------------------------------------
	// sequencer
	// ------------------------------------------------
	always_comb begin
		state_d = state_q;
		idx_d = idx_q;
		crc_d = crc_q;
		crcErr_d = crcErr_q;
		porDone_d = porDone_q;
		flag_d = flag_q && !statusRead;
		softRst_d = wrOk && (regAddr == ADDR_SOFT_RESET)
			&& (regWdata[7:0] == SOFT_RESET_CODE);
		case (state_q)
			ST_WAIT: begin
				// logic stays parked until supplies are good
				if (supplyOk) begin
					state_d = ST_TRIM;
					idx_d = 5'd0;
					crc_d = CRC_INIT;
				end
			end
			ST_IDLE: begin
				if (softRst_q && regs_q[IDX_SPECIAL][SPECIAL_TRIM_BIT]) begin
					state_d = ST_TRIM;
					idx_d = 5'd0;
					crc_d = CRC_INIT;
				end else if (wrOk && regAddr == ADDR_TRIGGER && regWdata[TRIG_SELF_BIT]) begin
					state_d = ST_SELF;
					idx_d = 5'd0;
					crc_d = CRC_INIT;
				end else if (wrOk && regAddr == ADDR_TRIGGER && regWdata[TRIG_TRIM_BIT]) begin
					state_d = ST_TRIM;
					idx_d = 5'd0;
					crc_d = CRC_INIT;
				end
			end
			ST_SELF: begin
				// one word a cycle keeps the run far shorter than a uart character
				crc_d = crcStep(crc_q, coverWord);
				idx_d = idx_q + 5'd1;
				if (idx_q == LAST_COVERED) begin
					state_d = ST_IDLE;
					flag_d = 1'b1;
					crcErr_d = (crc_d != 16'h0000);
				end
			end
			default: begin
				crc_d = crcStep(crc_q, trimData);
				idx_d = idx_q + 5'd1;
				if (idx_q == 5'(TRIM_WORDS - 1)) begin
					state_d = ST_IDLE;
					porDone_d = 1'b1;
				end
			end
		endcase
		if (hwRst) begin
			// no trim reload on the pin; an unfinished power-up restarts
			state_d = porDone_q ? ST_IDLE : ST_WAIT;
			softRst_d = 1'b0;
		end
		alarmPinN_d = porDone_d && !softRst_d;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_q <= ST_WAIT;
			idx_q <= 5'd0;
			crc_q <= CRC_INIT;
			flag_q <= 1'b0;
			crcErr_q <= 1'b0;
			porDone_q <= 1'b0;
			softRst_q <= 1'b0;
			alarmPinN_q <= 1'b0;
		end else begin
			state_q <= state_d;
			idx_q <= idx_d;
			crc_q <= crc_d;
			flag_q <= flag_d;
			crcErr_q <= crcErr_d;
			porDone_q <= porDone_d;
			softRst_q <= softRst_d;
			alarmPinN_q <= alarmPinN_d;
		end
	end

	// ------------------------------------------------
	// register file
	// ------------------------------------------------
	always_comb begin
		for (int i = 0; i < NUM_COVERED; i++) begin
			regs_d[i] = regs_q[i];
			// the reset pulse beats a write in the same cycle, except at the special register, which reset leaves alone
			if (regClr && i != IDX_SPECIAL) begin
				regs_d[i] = COVER_RESET[i];
			end else if (wrOk && regAddr == COVER_ADDR[i] && !COVER_RSVD[i]) begin
				regs_d[i] = regWdata;
			end
		end
		scratch_d = scratch_q;
		if (regClr) begin
			scratch_d = SCRATCH_RESET;
		end else if (wrOk && regAddr == ADDR_SCRATCH) begin
			scratch_d = regWdata;
		end
		// power-down follows its sources one cycle later through dacPd_q, data is never touched
		dacPd_d = regs_q[IDX_DAC_CFG][DAC_PD_BIT]
			|| |(alarmEvents & regs_q[IDX_ALARM_ACTION]);
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			for (int i = 0; i < NUM_COVERED; i++) begin
				regs_q[i] <= COVER_RESET[i];
			end
			scratch_q <= SCRATCH_RESET;
			dacPd_q <= 1'b0;
		end else begin
			regs_q <= regs_d;
			scratch_q <= scratch_d;
			dacPd_q <= dacPd_d;
		end
	end

	// ------------------------------------------------
	// read path
	// ------------------------------------------------
	always_comb begin
		rdValue = 16'h0000;
		if (regAddr == ADDR_SCRATCH) begin
			rdValue = ~scratch_q;
		end else if (regAddr == ADDR_TRIGGER) begin
			rdValue[TRIG_SELF_BIT] = regBusy;
			rdValue[TRIG_TRIM_BIT] = (state_q == ST_TRIM);
		end else if (regAddr == ADDR_CRC_RESULT) begin
			rdValue = crc_q;
		end else if (regAddr == ADDR_GENERAL_STATUS) begin
			rdValue[STATUS_SELF_BIT] = flag_q;
			rdValue[STATUS_CRCERR_BIT] = crcErr_q;
		end else begin
			for (int i = 0; i < NUM_COVERED; i++) begin
				if (regAddr == COVER_ADDR[i]) begin
					rdValue = regs_q[i];
				end
			end
		end
		rdata_d = rdOk ? rdValue : rdata_q;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign regRdata = rdata_q;
	assign dacPowerDown = dacPd_q;
	assign dacAmpEnable = ~dacPd_q;
	assign dacData = regs_q[IDX_DAC_DATA];
	assign trimLoading = (state_q == ST_TRIM);
	assign trimAddr = idx_q;
	assign alarmPinN = alarmPinN_q;

	// ------------------------------------------------
	// checks
	// ------------------------------------------------
	logic [11:0] porCnt_q;

	always_ff @(posedge clk_sys) begin
		if (reset || !supplyOk || porDone_q) begin
			porCnt_q <= 12'd0;
		end else begin
			porCnt_q <= porCnt_q + 12'd1;
		end
	end

	a_scratch_inverse: assert property (@(posedge clk_sys) disable iff (reset)
		rdOk && regAddr == ADDR_SCRATCH |=> regRdata == ~$past(scratch_q))
		else $error("scratch readback not inverted");
	a_selftest_length: assert property (@(posedge clk_sys) disable iff (reset || hwRst)
		$rose(regBusy) |-> regBusy [*8] ##14 regBusy ##1 !regBusy)
		else $error("self-test run length wrong");
	a_block_write: assert property (@(posedge clk_sys) disable iff (reset || hwRst)
		regBusy && regWrite |=> $stable(scratch_q) && $stable(regs_q[IDX_DAC_DATA]))
		else $error("write taken during self-test");
	a_flag_sticky: assert property (@(posedge clk_sys) disable iff (reset)
		flag_q && !statusRead |=> flag_q)
		else $error("status flag dropped without read");
	a_crc_verdict: assert property (@(posedge clk_sys) disable iff (reset || hwRst)
		$fell(regBusy) |-> flag_q && crcErr_q == (crc_q != 16'h0000))
		else $error("crc verdict mismatch");
	a_alarm_pd: assert property (@(posedge clk_sys) disable iff (reset)
		|(alarmEvents & regs_q[IDX_ALARM_ACTION]) |=> dacPowerDown && !dacAmpEnable)
		else $error("selected alarm did not power down");
	a_pd_data_kept: assert property (@(posedge clk_sys) disable iff (reset)
		dacPowerDown && !regWrite && !regClr |=> $stable(dacData))
		else $error("dac data changed in power-down");
	a_soft_pulse: assert property (@(posedge clk_sys) disable iff (reset || hwRst)
		porDone_q && softRst_d |=> !alarmPinN ##1 alarmPinN)
		else $error("soft reset alarm pulse wrong");
	a_special_kept: assert property (@(posedge clk_sys) disable iff (reset)
		regClr && !wrOk |=> $stable(regs_q[IDX_SPECIAL]))
		else $error("special config cleared by reset");
	a_soft_trim: assert property (@(posedge clk_sys) disable iff (reset || hwRst)
		softRst_q && state_q == ST_IDLE && regs_q[IDX_SPECIAL][SPECIAL_TRIM_BIT]
		|=> trimLoading)
		else $error("soft reset skipped trim reload");
	a_por_bound: assert property (@(posedge clk_sys) disable iff (reset)
		porCnt_q <= 12'(POR_MAX_CYCLES))
		else $error("power-on sequence too long");
	a_supply_hold: assert property (@(posedge clk_sys) disable iff (reset)
		!supplyOk && state_q == ST_WAIT |=> state_q == ST_WAIT && !alarmPinN)
		else $error("left power-up wait without supplies");
	a_read_blocked: assert property (@(posedge clk_sys) disable iff (reset)
		regBusy && regRead |=> $stable(regRdata))
		else $error("read taken during self-test");
	// a restart would pull the word index back to zero
	a_start_ignored: assert property (@(posedge clk_sys) disable iff (reset || hwRst)
		regBusy && regWrite && regAddr == ADDR_TRIGGER |=> idx_q == $past(idx_q) + 5'd1)
		else $error("running self-test restarted");
	a_crc_hold: assert property (@(posedge clk_sys) disable iff (reset)
		state_q == ST_IDLE && state_d == ST_IDLE |=> $stable(crc_q))
		else $error("crc result moved while idle");
	a_pd_bit: assert property (@(posedge clk_sys) disable iff (reset)
		regs_q[IDX_DAC_CFG][DAC_PD_BIT] |=> dacPowerDown && !dacAmpEnable)
		else $error("power-down bit ignored");
	a_alarm_release: assert property (@(posedge clk_sys) disable iff (reset)
		!regs_q[IDX_DAC_CFG][DAC_PD_BIT] && !(|(alarmEvents & regs_q[IDX_ALARM_ACTION]))
		|=> !dacPowerDown && dacAmpEnable)
		else $error("dac stayed down without a source");
	a_soft_clears: assert property (@(posedge clk_sys) disable iff (reset)
		softRst_q |=> scratch_q == SCRATCH_RESET && dacData == COVER_RESET[IDX_DAC_DATA])
		else $error("soft reset left registers set");
	a_pin_clears: assert property (@(posedge clk_sys) disable iff (reset)
		hwRst |=> scratch_q == SCRATCH_RESET && !trimLoading)
		else $error("reset pin left registers set");

	c_selftest_done: cover property (@(posedge clk_sys) disable iff (reset) $fell(regBusy));
	c_soft_reset: cover property (@(posedge clk_sys) disable iff (reset) softRst_q);
	c_alarm_pd: cover property (@(posedge clk_sys) disable iff (reset) $rose(dacPowerDown));
	c_trim_done: cover property (@(posedge clk_sys) disable iff (reset) $fell(trimLoading));
	c_pin_reset: cover property (@(posedge clk_sys) disable iff (reset) $fell(hwRst));

endmodule
`default_nettype wire

// file: test/trim_memory_model.sv
`timescale 1ns/1ps
`default_nettype none
module trim_memory_model (
	input wire logic [4:0] trimAddr,
	output logic [15:0] trimData
);
	// distinct word per index, so a skipped or repeated word changes the crc
	assign trimData = {trimAddr, 11'h2a5} ^ 16'h0f00;
endmodule
`default_nettype wire

// file: test/register_selftest_reset_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module register_selftest_reset_ctrl_tb import selftest_pkg::*;;
	localparam int TW = 4;
	logic clk_sys = 0, reset = 1, supplyValid = 1, resetPinN = 1, regWrite = 0, regRead = 0;
	logic [5:0] regAddr = '0;
	logic [15:0] regWdata = '0, alarmEvents = '0, regRdata, dacData, trimData, got, crc;
	logic regBusy, dacPowerDown, dacAmpEnable, trimLoading, alarmPinN;
	logic [4:0] trimAddr;
	int failures = 0, cmp_count = 0, lows = 0, trims = 0, n;
	typedef struct {logic [5:0] a; logic [15:0] d; logic w; logic [15:0] e;} row_t;
	row_t rows [8] = '{'{6'h03, 16'h0, 0, 16'h0b00}, '{6'h10, 16'h0, 0, 16'h8020},
		'{6'h0b, 16'h0, 0, 16'h0000}, '{6'h3f, 16'h0, 0, 16'h0000},
		'{6'h18, 16'haaaa, 1, 16'h5555}, '{6'h18, 16'h0000, 1, 16'hffff},
		'{6'h2a, 16'h1234, 1, 16'h0000}, '{6'h0d, 16'h1234, 1, 16'h0100}};
	logic [15:0] aev [5] = '{16'h0020, 16'h8020, 16'h8000, 16'h0000, 16'h0001};
	logic aexp [5] = '{1, 1, 1, 0, 0};

	register_selftest_reset_ctrl #(.TRIM_WORDS(TW)) DUT (.clk_sys(clk_sys), .reset(reset),
		.supplyValid(supplyValid), .resetPinN(resetPinN), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
		.regBusy(regBusy), .alarmEvents(alarmEvents), .dacPowerDown(dacPowerDown),
		.dacAmpEnable(dacAmpEnable), .dacData(dacData), .trimLoading(trimLoading),
		.trimAddr(trimAddr), .trimData(trimData), .alarmPinN(alarmPinN));
	trim_memory_model trimMem (.trimAddr(trimAddr), .trimData(trimData));

	initial begin
		forever #25 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (alarmPinN === 1'b0) lows++;
		if (trimLoading === 1'b1) trims++;
	end

	// ------------------------------------------------
	// tasks
	// ------------------------------------------------
	function automatic logic [15:0] crcRef(input logic [15:0] c, input logic [15:0] w);
		logic fb;
		for (int i = 15; i >= 0; i--) begin
			fb = c[15] ^ w[i];
			c = {c[14:0], 1'b0};
			if (fb) c = c ^ 16'h755b;
		end
		return c;
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("BAD %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		#1 regAddr = a;
		regWdata = d;
		regWrite = 1;
		@(posedge clk_sys);
		#1 regWrite = 0;
	endtask
	task automatic rd(input logic [5:0] a);
		@(posedge clk_sys);
		#1 regAddr = a;
		regRead = 1;
		@(posedge clk_sys);
		#1 regRead = 0;
		@(posedge clk_sys);
		#1 got = regRdata;
	endtask
	task automatic waitIdle(input int start);
		n = start;
		while (regBusy === 1'b1 && n < 100) begin
			@(posedge clk_sys);
			#1 n++;
		end
	endtask
	task automatic conclude;
		if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	initial begin
		#(30000 * 50);
		failures++;
		conclude();
	end

	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial begin
		repeat (4) @(posedge clk_sys);
		#1 reset = 0;
		trims = 0;
		n = 0;
		while (alarmPinN !== 1'b1 && n < 3000) begin
			@(posedge clk_sys);
			#1 n++;
		end
		chk(16'(n < 2000), 16'h1);
		chk(16'(trims), 16'(TW));
		foreach (rows[i]) begin
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			rd(rows[i].a);
			chk(got, rows[i].e);
		end
		// host-side expected value closes the list so a good setup ends at zero
		crc = '0;
		for (int i = 0; i < NUM_COVERED - 1; i++) crc = crcRef(crc, COVER_RESET[i]);
		wr(ADDR_EXP_CRC, crc);
		wr(ADDR_TRIGGER, 16'h0010);
		chk(16'(regBusy), 16'h1);
		wr(ADDR_SCRATCH, 16'h1111);
		wr(ADDR_TRIGGER, 16'h0010);
		waitIdle(4);
		chk(16'(n), 16'd22);
		rd(ADDR_GENERAL_STATUS);
		chk(got & 16'h3, 16'h1);
		rd(ADDR_GENERAL_STATUS);
		chk(got & 16'h1, 16'h0);
		rd(ADDR_CRC_RESULT);
		chk(got, 16'h0);
		rd(ADDR_SCRATCH);
		chk(got, 16'hffff);
		wr(ADDR_EXP_CRC, crc ^ 16'h1);
		wr(ADDR_TRIGGER, 16'h0010);
		waitIdle(0);
		rd(ADDR_GENERAL_STATUS);
		chk(got & 16'h3, 16'h3);
		rd(ADDR_CRC_RESULT);
		chk(16'(got != 0), 16'h1);
		foreach (aev[i]) begin
			@(posedge clk_sys);
			#1 alarmEvents = aev[i];
			repeat (2) @(posedge clk_sys);
			#1 chk(16'(dacPowerDown), 16'(aexp[i]));
			chk(16'(dacAmpEnable), 16'(!aexp[i]));
		end
		wr(ADDR_DAC_CFG, 16'h0b01);
		wr(6'h01, 16'h1234);
		chk(16'(dacPowerDown), 16'h1);
		chk(dacData, 16'h1234);
		wr(ADDR_DAC_CFG, 16'h0b00);
		@(posedge clk_sys);
		#1 chk(16'(dacPowerDown), 16'h0);
		chk(dacData, 16'h1234);
		wr(ADDR_SPECIAL, 16'h0001);
		wr(ADDR_SCRATCH, 16'h0005);
		lows = 0;
		trims = 0;
		crc = '0;
		for (int i = 0; i < TW; i++) crc = crcRef(crc, {5'(i), 11'h2a5} ^ 16'h0f00);
		// no access-mode register in this block; the host re-arms its link mode itself
		wr(ADDR_SOFT_RESET, 16'h00ad);
		// next command with no wait: it must land after the internal reset pulse
		wr(6'h01, 16'h4321);
		repeat (10) @(posedge clk_sys);
		#1 chk(16'(lows), 16'h1);
		chk(16'(trims), 16'(TW));
		chk(dacData, 16'h4321);
		rd(ADDR_CRC_RESULT);
		chk(got, crc);
		rd(ADDR_SPECIAL);
		chk(got, 16'h0001);
		rd(ADDR_SCRATCH);
		chk(got, 16'hffff);
		trims = 0;
		wr(ADDR_TRIGGER, 16'h0001);
		repeat (6) @(posedge clk_sys);
		#1 chk(16'(trims), 16'(TW));
		wr(ADDR_SCRATCH, 16'h0005);
		trims = 0;
		@(posedge clk_sys);
		// pin held three cycles, above the minimum low time
		#1 resetPinN = 0;
		repeat (3) @(posedge clk_sys);
		#1 resetPinN = 1;
		repeat (4) @(posedge clk_sys);
		rd(ADDR_SCRATCH);
		chk(got, 16'hffff);
		rd(ADDR_SPECIAL);
		chk(got, 16'h0001);
		chk(16'(trims), 16'h0);
		conclude();
	end
endmodule
`default_nettype wire
